//--- design/cmc_pkg.sv
// Package of constants for the computational mode control block
package cmc_pkg;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [3:0] CMC_OFF_MODE   = 4'h0; // mode_status_reg
   localparam logic [3:0] CMC_OFF_ICTL   = 4'h4; // interrupt_control_reg
   localparam logic [3:0] CMC_OFF_ARITH_STATUS_REG  = 4'h8; // arith_status_reg
   localparam logic [3:0] CMC_OFF_IRQST  = 4'hc; // event status, read clears
   localparam logic [3:0] CMC_OFF_IRQMSK = 4'h0; // event mask, bank 1
   localparam logic       CMC_BANK_MAIN  = 1'b0;
   localparam logic       CMC_BANK_AUX   = 1'b1;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CMC_MODE_STICKY_BIT = 2; // overflow_sticky_select
   localparam int CMC_MODE_SAT_BIT    = 3; // result_saturate_enable
   localparam int CMC_MODE_INT_BIT    = 4; // integer product mode
   localparam int CMC_ICTL_BIAS_BIT   = 7; // biased rounding
   localparam int CMC_AST_ZERO_BIT    = 0;
   localparam int CMC_AST_NEG_BIT     = 1;
   localparam int CMC_AST_OVF_BIT     = 2; // alu_overflow_flag
   localparam int CMC_AST_CARRY_BIT   = 3; // alu_carry_flag

   // ---------------------------------------------------------------
   // Reset values and constants
   // ---------------------------------------------------------------
   localparam logic [15:0] CMC_MODE_RST  = 16'h0000;
   localparam logic [15:0] CMC_ICTL_RST  = 16'h0000;
   localparam logic [3:0]  CMC_ARITH_STATUS_REG_RST = 4'h0;
   localparam logic [15:0] CMC_SAT_POS   = 16'h7fff;
   localparam logic [15:0] CMC_SAT_NEG   = 16'h8000;
   localparam logic [15:0] CMC_MIDPOINT  = 16'h8000;
   localparam logic [39:0] CMC_RND_ADD   = 40'h0000008000;
   localparam int          CMC_NUM_EVT   = 3; // overflow, carry, midpoint

   // ALU operation codes
   typedef enum logic [2:0] {
      CMC_OP_ADD  = 3'h0,
      CMC_OP_ADDC = 3'h1,
      CMC_OP_SUB  = 3'h2,
      CMC_OP_AND  = 3'h3,
      CMC_OP_OR   = 3'h4,
      CMC_OP_XOR  = 3'h5,
      CMC_OP_PASS = 3'h6,
      CMC_OP_NOT  = 3'h7
   } cmc_aluop_e;

   // Shifter operation codes
   typedef enum logic [1:0] {
      CMC_SH_LSL = 2'h0,
      CMC_SH_LSR = 2'h1,
      CMC_SH_ASL = 2'h2,
      CMC_SH_ASR = 2'h3
   } cmc_shop_e;

endpackage

//--- design/cmc_core.sv
// Computational mode control: ALU saturation/overflow, MAC format, rounding
//
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ps
// Operation
// [RL1] Integer product mode: no left shift, 32.0 result in middle and low words.
// [RL2] Mode bit 2 selects overflow flag non-sticky (0) or sticky (1).
// [RL3] Non-sticky: overflow flag clears on next non-overflowing ALU op or clear.
// [RL4] Sticky: overflow flag holds until software clears it explicitly.
// [RL5] Mode bit 3 enables saturation of signed ALU results.
// [RL6] Saturation off: ALU result written unchanged despite overflow.
// [RL7] Saturation on: overflow gives 0x7FFF if carry 0, 0x8000 if carry 1.
// [RL8] Saturation only for result register; feedback register wraps.
// [RL9] Mode bit 4 selects fractional 1.15 (0) or integer 16.0 (1) multiply.
// [RL10] Fractional: sign-extend product, shift left one, LSB zero.
// [RL11] Fractional result 1.31 in middle/low words; high word for accumulation.
// [RL12] Product added to or subtracted from 40-bit accumulator.
// [RL13] Control bit 7 selects unbiased (0) or biased (1) rounding.
// [RL14] Rounding at bit 15/16 boundary, carry reaches high word.
// [RL15] Unbiased: add one at bit 15, force bit 16 zero at exact midpoint.
// [RL16] Logical shifts unsigned, arithmetic shifts two's complement.
// [RL17] Biased: midpoint always rounds up; else as unbiased.
// [RL18] Status flags latched at end of cycle, visible next cycle.
// [RL19] Mode bit writes take effect from the next instruction.
module cmc_core
   import cmc_pkg::*;
#(
   parameter int DW = 16,
   parameter int AW = 40
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   // ALU instruction
   input wire logic alu_go_i,
   input wire logic [2:0] alu_op_i,
   input wire logic alu_to_fb_i,
   input wire logic alu_y_fb_i,
   input wire logic [DW-1:0] alu_x_i,
   input wire logic [DW-1:0] alu_y_i,
   // Multiplier instruction
   input wire logic mac_go_i,
   input wire logic mac_sub_i,
   input wire logic mac_clr_i,
   input wire logic mac_rnd_i,
   input wire logic mac_x_signed_i,
   input wire logic mac_y_signed_i,
   input wire logic [DW-1:0] mac_x_i,
   input wire logic [DW-1:0] mac_y_i,
   // Shifter instruction
   input wire logic sh_go_i,
   input wire logic [1:0] sh_op_i,
   input wire logic [4:0] sh_amt_i,
   input wire logic [DW-1:0] sh_x_i,
   // Results
   output logic [DW-1:0] alu_result_reg_o,
   output logic [DW-1:0] alu_feedback_reg_o,
   output logic [7:0] sum_high_byte_o,
   output logic [DW-1:0] sum_mid_word_o,
   output logic [DW-1:0] sum_low_word_o,
   output logic [2*DW-1:0] shifter_result_pair_o,
   output logic [3:0] arith_status_o
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] mode;
      logic [15:0] ictl;
      logic [3:0] arith_status_reg;
      logic [DW-1:0] ar;
      logic [DW-1:0] af;
      logic [AW-1:0] acc;
      logic [2*DW-1:0] shr;
      logic [CMC_NUM_EVT-1:0] evt;
      logic [CMC_NUM_EVT-1:0] msk;
      logic [31:0] rdat;
      logic ack;
   } cmc_state_s;

   cmc_state_s st_r;
   cmc_state_s st_nxt;

   // ---------------------------------------------------------------
   // Combinational datapath
   // ---------------------------------------------------------------
   logic [DW:0] alu_sum;
   logic [DW-1:0] alu_yop;
   logic [DW-1:0] alu_out;
   logic [DW-1:0] ar_val;
   logic alu_arith;
   logic alu_ovf;
   logic alu_cry;
   logic [2*DW-1:0] prod;
   logic [AW-1:0] prod_ext;
   logic [AW-1:0] acc_sum;
   logic [AW-1:0] acc_rnd;
   logic [2*DW-1:0] sh_res;
   logic at_mid;
   logic wb_req;
   logic wr_bus;
   logic rd_bus;
   logic [3:0] reg_idx;
   logic bank;

   // ALU core: sum with carry-out and two's complement overflow
   always_comb begin
      alu_yop = alu_y_fb_i ? st_r.af : alu_y_i;
      alu_sum = {1'b0, alu_x_i} + {1'b0, alu_yop};
      alu_out = alu_sum[DW-1:0];
      alu_arith = 1'b1;
      alu_ovf = 1'b0;
      alu_cry = 1'b0;
      unique case (cmc_aluop_e'(alu_op_i))
         CMC_OP_ADD: begin
            alu_sum = {1'b0, alu_x_i} + {1'b0, alu_yop};
         end
         CMC_OP_ADDC: begin
            alu_sum = {1'b0, alu_x_i} + {1'b0, alu_yop}
               + {{DW{1'b0}}, st_r.arith_status_reg[CMC_AST_CARRY_BIT]};
         end
         CMC_OP_SUB: begin
            alu_sum = {1'b0, alu_x_i} + {1'b0, ~alu_yop} + {{DW{1'b0}}, 1'b1};
         end
         default: begin
            alu_arith = 1'b0;
         end
      endcase
      if (alu_arith) begin
         alu_out = alu_sum[DW-1:0];
         alu_cry = alu_sum[DW];
         alu_ovf = (alu_x_i[DW-1] == (alu_op_i == CMC_OP_SUB ? ~alu_yop[DW-1]
            : alu_yop[DW-1])) && (alu_out[DW-1] != alu_x_i[DW-1]);
      end else begin
         unique case (cmc_aluop_e'(alu_op_i))
            CMC_OP_AND: alu_out = alu_x_i & alu_yop;
            CMC_OP_OR: alu_out = alu_x_i | alu_yop;
            CMC_OP_XOR: alu_out = alu_x_i ^ alu_yop;
            CMC_OP_PASS: alu_out = alu_x_i;
            default: alu_out = ~alu_x_i;
         endcase
      end
      // [RL5] Saturation per mode
      // [RL6] Unchanged when saturation off
      // [RL7] Clamp by carry sign
      ar_val = alu_out;
      if (st_r.mode[CMC_MODE_SAT_BIT] && alu_ovf) begin
         ar_val = alu_cry ? CMC_SAT_NEG : CMC_SAT_POS;
      end
   end

   // Multiplier, format adjust, accumulate and round
   always_comb begin
      logic signed [DW:0] xs;
      logic signed [DW:0] ys;
      logic signed [2*DW+1:0] pw;
      xs = {mac_x_signed_i & mac_x_i[DW-1], mac_x_i};
      ys = {mac_y_signed_i & mac_y_i[DW-1], mac_y_i};
      pw = xs * ys;
      prod = pw[2*DW-1:0];
      // [RL9] Mode bit selects format
      if (st_r.mode[CMC_MODE_INT_BIT]) begin
         // [RL1] Integer: no shift
         prod_ext = {{(AW-2*DW){prod[2*DW-1]}}, prod};
      end else begin
         // [RL10] Fractional: sign extend, shift one
         // [RL11] 1.31 lands in mid and low
         prod_ext = {{(AW-2*DW-1){prod[2*DW-1]}}, prod, 1'b0};
      end
      // [RL12] 40-bit add or subtract
      if (mac_clr_i) begin
         acc_sum = mac_sub_i ? -prod_ext : prod_ext;
      end else begin
         acc_sum = mac_sub_i ? st_r.acc - prod_ext : st_r.acc + prod_ext;
      end
      // [RL14] Round at bit 15/16
      at_mid = (acc_sum[DW-1:0] == CMC_MIDPOINT);
      acc_rnd = acc_sum + CMC_RND_ADD;
      // [RL13] Bias select
      // [RL15] Unbiased forces bit 16 low at midpoint
      // [RL17] Biased keeps round-up at midpoint
      if (at_mid && !st_r.ictl[CMC_ICTL_BIAS_BIT]) begin
         acc_rnd[DW] = 1'b0;
      end
   end

   // [RL16] Logical shifts unsigned, arithmetic signed
   always_comb begin
      logic [2*DW-1:0] ext;
      ext = {{DW{1'b0}}, sh_x_i};
      unique case (cmc_shop_e'(sh_op_i))
         CMC_SH_LSL: sh_res = ext << sh_amt_i;
         CMC_SH_LSR: sh_res = ext >> sh_amt_i;
         CMC_SH_ASL: sh_res = {{DW{sh_x_i[DW-1]}}, sh_x_i} << sh_amt_i;
         default: sh_res = $signed({{DW{sh_x_i[DW-1]}}, sh_x_i}) >>> sh_amt_i;
      endcase
   end

   // Bus decode
   assign wb_req = wb_cyc_i && wb_stb_i && !st_r.ack;
   assign wr_bus = wb_req && wb_we_i;
   assign rd_bus = wb_req && !wb_we_i;
   assign reg_idx = wb_adr_i[3:0];
   assign bank = wb_adr_i[4];

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [CMC_NUM_EVT-1:0] ev;
      st_nxt = st_r;
      ev = '0;
      st_nxt.ack = wb_req;
      // ALU writeback and flags
      if (alu_go_i) begin
         // [RL8] Feedback register wraps
         if (alu_to_fb_i) begin
            st_nxt.af = alu_out;
         end else begin
            st_nxt.ar = ar_val;
         end
         // [RL18] Flags latched this cycle
         st_nxt.arith_status_reg[CMC_AST_ZERO_BIT] = (ar_val == '0);
         st_nxt.arith_status_reg[CMC_AST_NEG_BIT] = ar_val[DW-1];
         st_nxt.arith_status_reg[CMC_AST_CARRY_BIT] = alu_cry;
         // [RL2] Sticky select
         // [RL3] Non-sticky clears on clean op
         // [RL4] Sticky holds
         if (alu_ovf) begin
            st_nxt.arith_status_reg[CMC_AST_OVF_BIT] = 1'b1;
         end else if (!st_r.mode[CMC_MODE_STICKY_BIT]) begin
            st_nxt.arith_status_reg[CMC_AST_OVF_BIT] = 1'b0;
         end
         ev[0] = alu_ovf;
         ev[1] = alu_cry;
      end
      if (mac_go_i) begin
         st_nxt.acc = mac_rnd_i ? acc_rnd : acc_sum;
         ev[2] = mac_rnd_i && at_mid;
      end
      if (sh_go_i) begin
         st_nxt.shr = sh_res;
      end
      // [RL19] Mode writes land after this cycle
      if (wr_bus && bank == CMC_BANK_MAIN) begin
         unique case (reg_idx)
            CMC_OFF_MODE: begin
               if (wb_sel_i[0]) st_nxt.mode[7:0] = wb_dat_i[7:0];
               if (wb_sel_i[1]) st_nxt.mode[15:8] = wb_dat_i[15:8];
            end
            CMC_OFF_ICTL: begin
               if (wb_sel_i[0]) st_nxt.ictl[7:0] = wb_dat_i[7:0];
               if (wb_sel_i[1]) st_nxt.ictl[15:8] = wb_dat_i[15:8];
            end
            CMC_OFF_ARITH_STATUS_REG: begin
               // [RL3] Explicit clear; a same-cycle ALU overflow still wins
               if (wb_sel_i[0]) st_nxt.arith_status_reg = wb_dat_i[3:0] | (alu_go_i ?
                  {1'b0, alu_ovf, 2'b00} : 4'h0);
            end
            default: begin
            end
         endcase
      end
      if (wr_bus && bank == CMC_BANK_AUX && reg_idx == CMC_OFF_IRQMSK && wb_sel_i[0]) begin
         st_nxt.msk = wb_dat_i[CMC_NUM_EVT-1:0];
      end
      // Read data; status read clears, new events win
      st_nxt.rdat = '0;
      if (rd_bus) begin
         if (bank == CMC_BANK_AUX) begin
            if (reg_idx == CMC_OFF_IRQMSK) st_nxt.rdat = {29'h0, st_r.msk};
         end else begin
            unique case (reg_idx)
               CMC_OFF_MODE: st_nxt.rdat = {16'h0, st_r.mode};
               CMC_OFF_ICTL: st_nxt.rdat = {16'h0, st_r.ictl};
               CMC_OFF_ARITH_STATUS_REG: st_nxt.rdat = {28'h0, st_r.arith_status_reg};
               CMC_OFF_IRQST: st_nxt.rdat = {29'h0, st_r.evt};
               default: st_nxt.rdat = '0;
            endcase
            if (reg_idx == CMC_OFF_IRQST) st_nxt.evt = '0;
         end
      end
      st_nxt.evt = st_nxt.evt | ev;
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '{mode: CMC_MODE_RST, ictl: CMC_ICTL_RST, arith_status_reg: CMC_ARITH_STATUS_REG_RST,
            default: '0};
      end else if (ce_i) begin
         st_r <= st_nxt;
      end
   end

   // Outputs
   assign wb_ack_o = st_r.ack;
   assign wb_dat_o = st_r.rdat;
   assign irq_o = |(st_r.evt & st_r.msk);
   assign alu_result_reg_o = st_r.ar;
   assign alu_feedback_reg_o = st_r.af;
   assign sum_high_byte_o = st_r.acc[AW-1:2*DW];
   assign sum_mid_word_o = st_r.acc[2*DW-1:DW];
   assign sum_low_word_o = st_r.acc[DW-1:0];
   assign shifter_result_pair_o = st_r.shr;
   assign arith_status_o = st_r.arith_status_reg;

endmodule

//--- verification/cmc_core_checker.sv
// Port assertions for the computational mode control block
`timescale 1ns/1ps
module cmc_core_checker
   import cmc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic alu_go_i,
   input wire logic [2:0] alu_op_i,
   input wire logic alu_to_fb_i,
   input wire logic [15:0] alu_x_i,
   input wire logic [15:0] alu_y_i,
   input wire logic [15:0] alu_result_reg_o,
   input wire logic [15:0] alu_feedback_reg_o,
   input wire logic [3:0] arith_status_o,
   input wire logic mac_go_i,
   input wire logic mac_sub_i,
   input wire logic mac_clr_i,
   input wire logic mac_rnd_i,
   input wire logic mac_x_signed_i,
   input wire logic mac_y_signed_i,
   input wire logic [15:0] mac_x_i,
   input wire logic [15:0] mac_y_i,
   input wire logic [7:0] sum_high_byte_o,
   input wire logic [15:0] sum_mid_word_o,
   input wire logic [15:0] sum_low_word_o
);
   // ---------------------------------------------------------------
   // Helper logic
   // ---------------------------------------------------------------
   logic [2:0] mode_r; // sticky, saturate, integer
   logic [16:0] sum;
   logic [15:0] s16;
   logic cy, ovf, keep, add_go, int_go;
   logic [31:0] pu;
   // Reference adder and operation qualifiers
   assign sum = {1'b0, alu_x_i} + {1'b0, alu_y_i};
   assign s16 = sum[15:0];
   assign cy = sum[16];
   assign ovf = (alu_x_i[15] == alu_y_i[15]) && (sum[15] != alu_x_i[15]);
   assign keep = ovf || (mode_r[0] && arith_status_o[CMC_AST_OVF_BIT]);
   assign add_go = alu_go_i && ce_i && !wb_stb_i && alu_op_i == CMC_OP_ADD;
   assign pu = mac_x_i * mac_y_i;
   assign int_go = mac_go_i && ce_i && mac_clr_i && !mac_rnd_i && !mac_sub_i
      && !mac_x_signed_i && !mac_y_signed_i && mode_r[2];
   // Mode bits as later operations see them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_r <= 3'h0;
      end else if (ce_i && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
         && wb_adr_i == 5'h00) begin
         mode_r <= wb_dat_i[4:2];
      end
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence wb_req;
      ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence ack_then_drop;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   ack_answer_a: assert property (wb_req |=> ack_then_drop)
      else $error("bus request not answered by a single ack");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack stood longer than one cycle");
   sat_clip_a: assert property (
      add_go && !alu_to_fb_i && mode_r[1] && ovf
      |=> alu_result_reg_o == ($past(cy) ? CMC_SAT_NEG : CMC_SAT_POS))
      else $error("saturated result wrong");
   sat_pass_a: assert property (
      add_go && !alu_to_fb_i && mode_r[1] && !ovf |=> alu_result_reg_o == $past(s16))
      else $error("unsaturated result altered");
   raw_result_a: assert property (
      add_go && !alu_to_fb_i && !mode_r[1] |=> alu_result_reg_o == $past(s16))
      else $error("result changed with saturation off");
   fb_wrap_a: assert property (
      add_go && alu_to_fb_i |=> alu_feedback_reg_o == $past(s16))
      else $error("feedback result did not wrap");
   ovf_flag_a: assert property (
      add_go |=> arith_status_o[CMC_AST_OVF_BIT] == $past(keep))
      else $error("overflow flag wrong");
   carry_flag_a: assert property (
      add_go |=> arith_status_o[CMC_AST_CARRY_BIT] == $past(cy))
      else $error("carry flag wrong");
   int_prod_a: assert property (
      int_go |=> {sum_high_byte_o, sum_mid_word_o, sum_low_word_o}
      == {{8{$past(pu[31])}}, $past(pu)})
      else $error("integer product misplaced");
endmodule
bind cmc_core cmc_core_checker i_chk (
   .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o,
   .alu_go_i, .alu_op_i, .alu_to_fb_i, .alu_x_i, .alu_y_i, .alu_result_reg_o,
   .alu_feedback_reg_o, .arith_status_o, .mac_go_i, .mac_sub_i, .mac_clr_i, .mac_rnd_i,
   .mac_x_signed_i, .mac_y_signed_i, .mac_x_i, .mac_y_i, .sum_high_byte_o, .sum_mid_word_o,
   .sum_low_word_o
);

//--- verification/cmc_issue_model.sv
// Instruction issue model standing in for the decoder and register file
`timescale 1ns/1ps
module cmc_issue_model (
   input wire logic clk_i,
   output logic alu_go_o,
   output logic [2:0] alu_op_o,
   output logic alu_to_fb_o,
   output logic alu_y_fb_o,
   output logic [15:0] alu_x_o,
   output logic [15:0] alu_y_o,
   output logic mac_go_o,
   output logic mac_sub_o,
   output logic mac_clr_o,
   output logic mac_rnd_o,
   output logic mac_sgn_o,
   output logic [15:0] mac_x_o,
   output logic [15:0] mac_y_o
);
   // Idle instruction lines
   initial begin
      {alu_go_o, alu_op_o, alu_to_fb_o, alu_y_fb_o, alu_x_o, alu_y_o} = '0;
      {mac_go_o, mac_sub_o, mac_clr_o, mac_rnd_o, mac_sgn_o, mac_x_o, mac_y_o} = '0;
   end
   // One ALU instruction; operands stop being valid afterwards
   task automatic alu(input logic [2:0] op, input logic fb, input logic [15:0] x, y);
      @(posedge clk_i);
      alu_go_o <= 1'b1;
      alu_op_o <= op;
      alu_to_fb_o <= fb;
      alu_x_o <= x;
      alu_y_o <= y;
      @(posedge clk_i);
      alu_go_o <= 1'b0;
      alu_x_o <= ~x;
      alu_y_o <= ~y;
   endtask
   // One multiply instruction
   task automatic mac(input logic sub, clr, rnd, sgn, input logic [15:0] x, y);
      @(posedge clk_i);
      {mac_go_o, mac_sub_o, mac_clr_o, mac_rnd_o, mac_sgn_o} <= {1'b1, sub, clr, rnd, sgn};
      mac_x_o <= x;
      mac_y_o <= y;
      @(posedge clk_i);
      mac_go_o <= 1'b0;
      mac_x_o <= ~x;
      mac_y_o <= ~y;
   endtask
endmodule

//--- verification/tb.sv
// Self-checking testbench of the computational mode control block
`timescale 1ns/1ps
module tb
   import cmc_pkg::*;
;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
   logic [4:0] wb_adr_i;
   logic [3:0] wb_sel_i, arith_status_o;
   logic [31:0] wb_dat_i, wb_dat_o, d;
   logic alu_go_i, alu_to_fb_i, alu_y_fb_i, mac_go_i, mac_sub_i, mac_clr_i, mac_rnd_i, sgn;
   logic [2:0] alu_op_i;
   logic [15:0] alu_x_i, alu_y_i, mac_x_i, mac_y_i;
   logic [15:0] alu_result_reg_o, alu_feedback_reg_o, sum_mid_word_o, sum_low_word_o;
   logic [7:0] sum_high_byte_o;
   logic sh_go_i;
   logic [1:0] sh_op_i;
   logic [4:0] sh_amt_i;
   logic [15:0] sh_x_i;
   logic [31:0] shifter_result_pair_o;
   int n_mismatch = 0;
   int checks = 0;
   cmc_core i_dut (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .alu_go_i, .alu_op_i, .alu_to_fb_i,
      .alu_y_fb_i, .alu_x_i, .alu_y_i, .mac_go_i, .mac_sub_i, .mac_clr_i, .mac_rnd_i,
      .mac_x_signed_i(sgn), .mac_y_signed_i(sgn), .mac_x_i, .mac_y_i, .sh_go_i,
      .sh_op_i, .sh_amt_i, .sh_x_i, .alu_result_reg_o,
      .alu_feedback_reg_o, .sum_high_byte_o, .sum_mid_word_o, .sum_low_word_o,
      .shifter_result_pair_o, .arith_status_o);
   cmc_issue_model i_iss (.clk_i, .alu_go_o(alu_go_i), .alu_op_o(alu_op_i),
      .alu_to_fb_o(alu_to_fb_i), .alu_y_fb_o(alu_y_fb_i), .alu_x_o(alu_x_i),
      .alu_y_o(alu_y_i), .mac_go_o(mac_go_i), .mac_sub_o(mac_sub_i), .mac_clr_o(mac_clr_i),
      .mac_rnd_o(mac_rnd_i), .mac_sgn_o(sgn), .mac_x_o(mac_x_i), .mac_y_o(mac_y_i));
   // Clock of 40 ns
   always #20 clk_i = ~clk_i;
   // Compare a value with its expectation
   task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Classic single bus cycle
   task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] w);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'b11, we, 4'hf, a, w};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      d = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= 7'h00;
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      cmp(d, e);
   endtask
   task automatic do_alu(input logic fb, input logic [15:0] x, y);
      i_iss.alu(CMC_OP_ADD, fb, x, y);
      #1;
   endtask
   task automatic do_mac(input logic sub, clr, rnd, s, input logic [15:0] x, y);
      i_iss.mac(sub, clr, rnd, s, x, y);
      #1;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      rdchk(5'h04, 32'h0);
      wb(1'b1, 5'h00, 32'h1c);
      rdchk(5'h00, 32'h1c);
      wb(1'b1, 5'h14, 32'hffff);
      rdchk(5'h14, 32'h0);
   endtask
   task automatic t_sat();
      wb(1'b1, 5'h00, 32'h08);
      do_alu(1'b0, 16'h7fff, 16'h0001);
      cmp(alu_result_reg_o, 16'h7fff);
      cmp(arith_status_o, 4'h4);
      do_alu(1'b0, 16'h8000, 16'h8000);
      cmp({alu_result_reg_o, arith_status_o}, 20'h8000e);
      do_alu(1'b1, 16'h7fff, 16'h0001);
      cmp(alu_feedback_reg_o, 16'h8000);
      wb(1'b1, 5'h00, 32'h0);
      do_alu(1'b0, 16'h7fff, 16'h0001);
      cmp(alu_result_reg_o, 16'h8000);
   endtask
   task automatic t_sticky();
      do_alu(1'b0, 16'h0001, 16'h0001);
      cmp(arith_status_o[CMC_AST_OVF_BIT], 1'b0);
      wb(1'b1, 5'h00, 32'h04);
      do_alu(1'b0, 16'h7fff, 16'h0001);
      do_alu(1'b0, 16'h0001, 16'h0001);
      cmp(arith_status_o[CMC_AST_OVF_BIT], 1'b1);
      wb(1'b1, 5'h08, 32'h0);
      #1;
      cmp(arith_status_o[CMC_AST_OVF_BIT], 1'b0);
      wb(1'b1, 5'h00, 32'h0);
   endtask
   task automatic t_mac();
      wb(1'b1, 5'h00, 32'h10);
      do_mac(1'b0, 1'b1, 1'b0, 1'b0, 16'h0003, 16'h0004);
      cmp({sum_high_byte_o, sum_mid_word_o, sum_low_word_o}, 40'hc);
      wb(1'b1, 5'h00, 32'h0);
      do_mac(1'b0, 1'b1, 1'b0, 1'b1, 16'h4000, 16'h4000);
      cmp({sum_high_byte_o, sum_mid_word_o, sum_low_word_o}, 40'h20000000);
      do_mac(1'b0, 1'b0, 1'b0, 1'b1, 16'h8000, 16'h4000);
      cmp({sum_high_byte_o, sum_mid_word_o, sum_low_word_o}, 40'hffe0000000);
      do_mac(1'b1, 1'b0, 1'b0, 1'b1, 16'h8000, 16'h4000);
      cmp({sum_high_byte_o, sum_mid_word_o, sum_low_word_o}, 40'h20000000);
   endtask
   task automatic t_rnd();
      wb(1'b1, 5'h00, 32'h10);
      do_mac(1'b0, 1'b1, 1'b1, 1'b0, 16'h8000, 16'h0001);
      cmp({sum_high_byte_o, sum_mid_word_o}, 24'h0);
      do_mac(1'b0, 1'b1, 1'b1, 1'b0, 16'h8000, 16'h0003);
      cmp({sum_high_byte_o, sum_mid_word_o}, 24'h2);
      do_mac(1'b0, 1'b1, 1'b0, 1'b0, 16'hffff, 16'hffff);
      do_mac(1'b0, 1'b0, 1'b1, 1'b0, 16'h8000, 16'h0003);
      cmp({sum_high_byte_o, sum_mid_word_o}, 24'h000000);
      wb(1'b1, 5'h04, 32'h80);
      do_mac(1'b0, 1'b1, 1'b1, 1'b0, 16'h8000, 16'h0001);
      cmp({sum_high_byte_o, sum_mid_word_o}, 24'h1);
      wb(1'b1, 5'h04, 32'h0);
   endtask
   task automatic t_irq();
      wb(1'b1, 5'h10, 32'h1);
      wb(1'b0, 5'h0c, 32'h0);
      do_alu(1'b0, 16'h7fff, 16'h0001);
      @(posedge clk_i);
      #1;
      cmp(irq_o, 1'b1);
      rdchk(5'h0c, 32'h1);
      @(posedge clk_i);
      #1;
      cmp(irq_o, 1'b0);
      wb(1'b1, 5'h10, 32'h0);
      do_alu(1'b0, 16'h7fff, 16'h0001);
      @(posedge clk_i);
      #1;
      cmp(irq_o, 1'b0);
      rdchk(5'h0c, 32'h1);
   endtask
   task automatic t_shift();
      @(posedge clk_i);
      {sh_go_i, sh_op_i, sh_amt_i, sh_x_i} <= {1'b1, 2'h3, 5'h04, 16'h8000};
      @(posedge clk_i);
      sh_op_i <= 2'h1;
      #1;
      cmp(shifter_result_pair_o, 32'hfffff800);
      @(posedge clk_i);
      sh_go_i <= 1'b0;
      #1;
      cmp(shifter_result_pair_o, 32'h00000800);
   endtask
   // Verdict and end of run
   task automatic summarize();
      if (n_mismatch == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Reset, then the scenarios in turn
   initial begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} = '0;
      {sh_go_i, sh_op_i, sh_amt_i, sh_x_i} = '0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_sat();
      t_sticky();
      t_mac();
      t_rnd();
      t_irq();
      t_shift();
      summarize();
   end
   // Watchdog against a hung handshake
   initial begin
      #200000;
      n_mismatch++;
      summarize();
   end
endmodule
